/* rtl/fxs_consts.svh */
// Constants for the extended read status block: field positions, reset values,
// opcodes, dummy counts and drive codes.
// Assumes inclusion by bare name from the package and the block's modules.
`ifndef FXS_CONSTS_SVH
`define FXS_CONSTS_SVH

// ============================================================
// Register layout
`define FXS_BIT_BUSY 0
`define FXS_BIT_PROT 1
`define FXS_BIT_PERR 2
`define FXS_BIT_EERR 3
`define FXS_BIT_RSVD 4
`define FXS_STR_LSB 5
`define FXS_STR_MSB 7
`define FXS_RESET_VAL 8'hf0
`define FXS_STR_DEFAULT 3'h7
`define FXS_RSVD_VAL 1'h1

// ============================================================
// Opcodes
`define FXS_OP_SET_NV 8'h85
`define FXS_OP_SET_V 8'h83
`define FXS_OP_CLEAR 8'h82
`define FXS_OP_FAST 8'h0b
`define FXS_OP_FAST_DTR 8'h0d
`define FXS_OP_DUAL_OUT 8'h3b
`define FXS_OP_DUAL_IO 8'hbb
`define FXS_OP_DUAL_IO_DTR 8'hbd
`define FXS_OP_QUAD_OUT 8'h6b
`define FXS_OP_QUAD_IO 8'heb
`define FXS_OP_QUAD_IO_DTR 8'hed
`define FXS_OP_UID 8'h4b
`define FXS_OP_SFDP 8'h5a
`define FXS_OP_INFO_ROW_READ_CMD 8'h68

// ============================================================
// Default dummy counts
`define FXS_DUMMY_SPI 4'h8
`define FXS_DUMMY_QPI 4'h6
`define FXS_DUMMY_DUAL_IO 4'h4
`define FXS_DUMMY_QUAD_IO 4'h6
`define FXS_DUMMY_NONE 4'h0

// ============================================================
// Drive strength in eighths of full drive (12.5% steps)
`define FXS_DRV_RSVD 4'h0
`define FXS_DRV_12 4'h1
`define FXS_DRV_25 4'h2
`define FXS_DRV_37 4'h3
`define FXS_DRV_50 4'h4
`define FXS_DRV_75 4'h6
`define FXS_DRV_100 4'h8

`endif

/* rtl/fxs_pkg.sv */
// Types for the extended read status block.
// Assumes fxs_consts.svh is on the include path.
package fxs_pkg;
`include "fxs_consts.svh"

    // Error event kinds reported by the array engine
    typedef enum logic [3:0] {
        FXS_EV_NONE,
        FXS_EV_PROG_FAIL,
        FXS_EV_PROG_PROT,
        FXS_EV_IR_PROG_FAIL,
        FXS_EV_IR_PROG_LOCK,
        FXS_EV_REG_ERASE_FAIL,
        FXS_EV_REG_PROG_FAIL,
        FXS_EV_SR_LOCKED,
        FXS_EV_FUNC_FAIL,
        FXS_EV_ERASE_FAIL,
        FXS_EV_ERASE_PROT,
        FXS_EV_CHIP_ERASE_PROT
    } fxs_event_e;

    // Command handling state
    typedef enum logic [1:0] {
        FXS_IDLE,
        FXS_OPCODE,
        FXS_DATA,
        FXS_IGNORE
    } fxs_state_e;

    // Serial front end state
    typedef struct packed {
        logic [2:0] sck_sync;
        logic [2:0] csn_sync;
        logic [2:0] din_sync;
        logic qpi;
        logic [2:0] bitcnt;
        logic [7:0] shreg;
        logic byte_valid;
        logic frame_start;
    } fxs_rx_s;

    // Register block state
    typedef struct packed {
        fxs_state_e state;
        logic [7:0] opcode;
        logic [2:0] str_nv;
        logic [2:0] str_v;
        logic perr;
        logic eerr;
        logic prot;
        logic [7:0] rd_value;
        logic [3:0] dummy;
        logic cmd_ok;
        logic [3:0] drive;
        logic nv_req;
        logic [2:0] nv_data;
        logic [2:0] last_srcode;
    } fxs_state_s;
endpackage

/* rtl/fxs_rx.sv */
// Serial byte receiver: synchronises the link clock, select and data pin.
// Assumes the link clock is far slower than clk and arrives on a pin.
`timescale 1ns/100ps
module fxs_rx (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic sck,
    input wire logic csn,
    input wire logic din,
    input wire logic qpi_mode,
    output logic [7:0] rx_byte,
    output logic rx_valid,
    output logic rx_start,
    output logic rx_active,
    output logic rx_qpi
);
    import fxs_pkg::*;

    fxs_rx_s r;
    fxs_rx_s next_r;
    logic sck_rise;
    logic sel;

    // ============================================================
    // Edge finding and shifting
    always_comb begin
        next_r = r;
        next_r.sck_sync = {r.sck_sync[1:0], sck};
        next_r.csn_sync = {r.csn_sync[1:0], csn};
        next_r.din_sync = {r.din_sync[1:0], din};
        next_r.byte_valid = 1'b0;
        next_r.frame_start = 1'b0;
        sel = (r.csn_sync[2:1] == 2'b00);
        sck_rise = (r.sck_sync[2:1] == 2'b01) && sel;
        if (r.csn_sync[2:1] == 2'b10) begin
            next_r.bitcnt = 3'h0;
            next_r.frame_start = 1'b1;
            next_r.qpi = qpi_mode;
        end else if (!sel) begin
            next_r.bitcnt = 3'h0;
        end else if (sck_rise) begin
            // MSB first, one bit per rising edge
            next_r.shreg = {r.shreg[6:0], r.din_sync[2]};
            next_r.bitcnt = r.bitcnt + 3'h1;
            if (r.bitcnt == 3'h7) begin
                next_r.byte_valid = 1'b1;
            end
        end
    end

    // Register the state
    always_ff @(posedge clk) begin
        if (srst) begin
            r <= '0;
            r.sck_sync <= 3'h0;
            r.csn_sync <= 3'h7;
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign rx_byte = r.shreg;
    assign rx_valid = r.byte_valid;
    assign rx_start = r.frame_start;
    assign rx_active = (r.csn_sync[2:1] == 2'b00);
    assign rx_qpi = r.qpi;
endmodule // fxs_rx

/* rtl/fxs_ext_status.sv */
// Extended read status register: drive strength, sticky error flags, busy
// mirror, set and clear commands and default dummy counts per read opcode.
// Assumes a host drives the link pins; array engine pulses error events.
`timescale 1ns/100ps
`include "fxs_consts.svh"
module fxs_ext_status (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic sck,
    input wire logic csn,
    input wire logic din,
    input wire logic qpi_mode,
    input wire logic soft_reset,
    input wire logic status_busy,
    input wire logic nv_busy,
    input wire fxs_pkg::fxs_event_e err_event,
    output logic [7:0] ext_status,
    output logic [3:0] dummy_cycles,
    output logic dummy_valid,
    output logic [3:0] drive_eighths,
    output logic nv_write_req,
    output logic [2:0] nv_write_data,
    output logic cmd_rejected
);
    import fxs_pkg::*;

    fxs_state_s s;
    fxs_state_s next_s;
    logic [7:0] rx_byte;
    logic rx_valid;
    logic rx_start;
    logic rx_active;
    logic rx_qpi;
    logic busy_q;
    logic rej_q;
    logic next_rej;
    logic [3:0] dummy_sel;
    logic dummy_hit;

    // ============================================================
    // Link receiver
    fxs_rx u_rx (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .sck(sck),
        .csn(csn),
        .din(din),
        .qpi_mode(qpi_mode),
        .rx_byte(rx_byte),
        .rx_valid(rx_valid),
        .rx_start(rx_start),
        .rx_active(rx_active),
        .rx_qpi(rx_qpi)
    );

    // ============================================================
    // Helpers

    // Default dummy clocks for a read opcode; zero means no such read here
    function automatic logic [3:0] dummy_default(input logic [7:0] op, input logic qpi);
        logic [3:0] d;
        d = `FXS_DUMMY_NONE;
        if (op == `FXS_OP_FAST || op == `FXS_OP_FAST_DTR || op == `FXS_OP_UID
            || op == `FXS_OP_SFDP || op == `FXS_OP_INFO_ROW_READ_CMD) begin
            d = qpi ? `FXS_DUMMY_QPI : `FXS_DUMMY_SPI;
        end else if (op == `FXS_OP_DUAL_OUT && !qpi) begin
            d = `FXS_DUMMY_SPI;
        end else if ((op == `FXS_OP_DUAL_IO || op == `FXS_OP_DUAL_IO_DTR) && !qpi) begin
            d = `FXS_DUMMY_DUAL_IO;
        end else if (op == `FXS_OP_QUAD_OUT && !qpi) begin
            d = `FXS_DUMMY_SPI;
        end else if (op == `FXS_OP_QUAD_IO || op == `FXS_OP_QUAD_IO_DTR) begin
            d = `FXS_DUMMY_QUAD_IO;
        end
        return d;
    endfunction

    // Drive strength code to eighths of full drive
    function automatic logic [3:0] drive_decode(input logic [2:0] code);
        logic [3:0] v;
        case (code)
            3'h1: v = `FXS_DRV_12;
            3'h2: v = `FXS_DRV_25;
            3'h3: v = `FXS_DRV_37;
            3'h5: v = `FXS_DRV_75;
            3'h6: v = `FXS_DRV_100;
            3'h7: v = `FXS_DRV_50;
            default: v = `FXS_DRV_RSVD;
        endcase
        return v;
    endfunction

    // Assemble the readable register image
    function automatic logic [7:0] pack_reg(input logic [2:0] str, input logic ee,
                                            input logic pe, input logic pr, input logic b);
        logic [7:0] v;
        v = 8'h00;
        v[`FXS_STR_MSB:`FXS_STR_LSB] = str;
        v[`FXS_BIT_RSVD] = `FXS_RSVD_VAL;
        v[`FXS_BIT_EERR] = ee;
        v[`FXS_BIT_PERR] = pe;
        v[`FXS_BIT_PROT] = pr;
        v[`FXS_BIT_BUSY] = b;
        return v;
    endfunction

    assign dummy_sel = dummy_default(rx_byte, rx_qpi);
    assign dummy_hit = (dummy_sel != `FXS_DUMMY_NONE);

    // ============================================================
    // Command decode, error flags and register copies
    always_comb begin
        logic set_p;
        logic set_e;
        logic set_x;
        set_p = 1'b0;
        set_e = 1'b0;
        set_x = 1'b0;
        next_s = s;
        next_s.nv_req = 1'b0;
        next_rej = 1'b0;

        // Event decoding into flag sets
        case (err_event)
            FXS_EV_PROG_FAIL: set_p = 1'b1;
            FXS_EV_PROG_PROT: begin
                set_p = 1'b1;
                set_x = 1'b1;
            end
            FXS_EV_IR_PROG_FAIL: set_p = 1'b1;
            FXS_EV_IR_PROG_LOCK: begin
                set_p = 1'b1;
                set_x = 1'b1;
            end
            FXS_EV_REG_ERASE_FAIL: set_e = 1'b1;
            FXS_EV_REG_PROG_FAIL: set_p = 1'b1;
            FXS_EV_SR_LOCKED: begin
                set_x = 1'b1;
                set_e = 1'b1;
            end
            FXS_EV_FUNC_FAIL: set_p = 1'b1;
            FXS_EV_ERASE_FAIL: set_e = 1'b1;
            FXS_EV_ERASE_PROT: begin
                set_e = 1'b1;
                set_x = 1'b1;
            end
            FXS_EV_CHIP_ERASE_PROT: set_e = 1'b0;
            default: set_e = 1'b0;
        endcase

        // Frame sequencing
        case (s.state)
            FXS_IDLE: begin
                if (rx_start) begin
                    next_s.state = FXS_OPCODE;
                end
            end
            FXS_OPCODE: begin
                if (rx_valid) begin
                    next_s.opcode = rx_byte;
                    next_s.state = FXS_IGNORE;
                    if (rx_byte == `FXS_OP_CLEAR) begin
                        next_s.eerr = 1'b0;
                        next_s.perr = 1'b0;
                        next_s.prot = 1'b0;
                    end else if (rx_byte == `FXS_OP_SET_NV || rx_byte == `FXS_OP_SET_V) begin
                        next_s.state = FXS_DATA;
                    end else if (dummy_hit) begin
                        next_s.dummy = dummy_sel;
                        next_s.cmd_ok = 1'b1;
                    end else if (rx_byte == `FXS_OP_DUAL_IO_DTR) begin
                        next_rej = 1'b1;
                        next_s.cmd_ok = 1'b0;
                    end
                end else if (!rx_active) begin
                    next_s.state = FXS_IDLE;
                end
            end
            FXS_DATA: begin
                if (rx_valid) begin
                    // Only the strength field is taken; bits 4:0 of data ignored
                    if (s.opcode == `FXS_OP_SET_NV) begin
                        next_s.nv_req = 1'b1;
                        next_s.nv_data = rx_byte[`FXS_STR_MSB:`FXS_STR_LSB];
                        next_s.str_nv = rx_byte[`FXS_STR_MSB:`FXS_STR_LSB];
                    end else begin
                        next_s.str_v = rx_byte[`FXS_STR_MSB:`FXS_STR_LSB];
                    end
                    next_s.state = FXS_IGNORE;
                end else if (!rx_active) begin
                    next_s.state = FXS_IDLE;
                end
            end
            FXS_IGNORE: begin
                if (!rx_active) begin
                    next_s.state = FXS_IDLE;
                    next_s.cmd_ok = 1'b0;
                end
            end
            default: next_s.state = FXS_IDLE;
        endcase

        // Error sets win over a clear in the same cycle
        if (set_e) begin
            next_s.eerr = 1'b1;
        end
        if (set_p) begin
            next_s.perr = 1'b1;
        end
        if (set_x) begin
            next_s.prot = 1'b1;
        end

        // Soft reset: clear flags, reload volatile strength
        if (soft_reset) begin
            next_s.eerr = set_e;
            next_s.perr = set_p;
            next_s.prot = set_x;
            next_s.str_v = s.str_nv;
            next_s.state = FXS_IDLE;
            next_s.cmd_ok = 1'b0;
        end

        next_s.drive = drive_decode(next_s.str_v);
        next_s.rd_value = pack_reg(next_s.str_v, next_s.eerr, next_s.perr,
                                   next_s.prot, busy_q | nv_busy);
        next_s.last_srcode = next_s.str_v;
    end

    // Register the state; busy mirror sampled each cycle that ce is high
    always_ff @(posedge clk) begin
        if (srst) begin
            s <= '0;
            s.state <= FXS_IDLE;
            s.str_nv <= `FXS_STR_DEFAULT;
            s.str_v <= `FXS_STR_DEFAULT;
            s.rd_value <= `FXS_RESET_VAL;
            s.drive <= `FXS_DRV_50;
            s.last_srcode <= `FXS_STR_DEFAULT;
            busy_q <= 1'b0;
            rej_q <= 1'b0;
        end else if (ce) begin
            s <= next_s;
            busy_q <= status_busy;
            rej_q <= next_rej;
        end
    end

    // ============================================================
    // Outputs, all from flip-flops
    assign ext_status = s.rd_value;
    assign dummy_cycles = s.dummy;
    assign dummy_valid = s.cmd_ok;
    assign drive_eighths = s.drive;
    assign nv_write_req = s.nv_req;
    assign nv_write_data = s.nv_data;
    assign cmd_rejected = rej_q;
endmodule // fxs_ext_status

/* verification/fxs_ext_status_checker.sv */
// Checker for the extended read status block: flags, busy mirror, drive map.
// Assumes it is bound to fxs_ext_status and sees only its ports.
`timescale 1ns/100ps
module fxs_ext_status_checker (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic csn,
    input wire logic soft_reset,
    input wire logic status_busy,
    input wire logic nv_busy,
    input wire fxs_pkg::fxs_event_e err_event,
    input wire logic [7:0] ext_status,
    input wire logic [3:0] dummy_cycles,
    input wire logic dummy_valid,
    input wire logic [3:0] drive_eighths,
    input wire logic nv_write_req,
    input wire logic cmd_rejected
);
    import fxs_pkg::*;
    // Drive in eighths per strength code, one nibble per code
    localparam logic [31:0] drv_lut = 32'h4860_3210;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // ============================================================
    // Register image
    rsvd_bit_a: assert property (ext_status[4] == 1'b1)
        else $error("reserved bit not one");
    // Status busy passes two flops (mirror then image), non-volatile busy one
    busy_mirror_a: assert property (
        !$past(srst) && !$past(srst, 2) && $past(ce) && $past(ce, 2)
        |-> ext_status[0] == ($past(status_busy, 2) | $past(nv_busy)))
        else $error("busy bit does not follow status");
    drive_map_a: assert property (
        drive_eighths == drv_lut[ext_status[7:5] * 4 +: 4])
        else $error("drive level does not match strength code");
    // ============================================================
    // Error flags
    erase_prot_a: assert property (
        ce && err_event == FXS_EV_ERASE_PROT |=> ext_status[3] && ext_status[1])
        else $error("erase on protected target lost a flag");
    prog_fail_a: assert property (
        ce && err_event inside {FXS_EV_PROG_FAIL, FXS_EV_IR_PROG_FAIL,
            FXS_EV_REG_PROG_FAIL, FXS_EV_FUNC_FAIL} |=> ext_status[2])
        else $error("program failure not flagged");
    chip_erase_a: assert property (
        ce && err_event == FXS_EV_CHIP_ERASE_PROT && ext_status[3:1] == 3'h0
        |=> ext_status[3] == 1'b0 && ext_status[1] == 1'b0)
        else $error("chip erase raised a flag");
    sticky_err_a: assert property (
        ext_status[2] && !soft_reset && csn && $past(csn, 8) |=> ext_status[2])
        else $error("program error dropped without a clear");
    soft_clear_a: assert property (
        ce && soft_reset && err_event == FXS_EV_NONE |=> ext_status[3:1] == 3'h0)
        else $error("soft reset left a flag set");
    // ============================================================
    // Command outputs
    nv_pulse_a: assert property (nv_write_req |=> !nv_write_req)
        else $error("write request longer than one cycle");
    reject_a: assert property (cmd_rejected |-> !dummy_valid)
        else $error("refused read still gave a dummy count");
    dummy_set_a: assert property (
        dummy_valid |-> dummy_cycles inside {4'h4, 4'h6, 4'h8})
        else $error("dummy count outside the default set");
    cover property (dummy_valid);
    cover property (cmd_rejected);
    cover property (nv_write_req);
    cover property (soft_reset && ext_status[2]);
endmodule // fxs_ext_status_checker

/* verification/fxs_host_model.sv */
// Host flash controller model: drives link clock, select and data pin.
// Assumes clk runs at 100 ns; the link clock is 8 clk per period.
`timescale 1ns/100ps
module fxs_host_model (
    input wire logic clk,
    output logic sck,
    output logic csn,
    output logic din,
    output logic qpi_mode
);
    // Idle: clock still low, not selected
    initial begin
        sck = 1'b0;
        csn = 1'b1;
        din = 1'b0;
        qpi_mode = 1'b0;
    end
    // Sends n bytes MSB first and leaves the device selected
    // No mode bits are sent, so the shared lines never clash
    task automatic send(input int n, input logic [15:0] data, input logic q);
        qpi_mode <= q;
        @(posedge clk);
        csn <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 15; i >= 16 - 8 * n; i--) begin
            din <= data[i];
            sck <= 1'b0;
            repeat (4) @(posedge clk);
            sck <= 1'b1;
            repeat (4) @(posedge clk);
        end
        sck <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    // Deselects; the released data line shows the inverse of its last bit
    task automatic finish_frame();
        csn <= 1'b1;
        din <= ~din;
        repeat (8) @(posedge clk);
    endtask
endmodule // fxs_host_model

/* verification/fxs_ext_status_tb.sv */
// Testbench for the extended read status block.
// Assumes fxs_pkg is compiled first; host model drives the link pins.
`timescale 1ns/100ps
module fxs_ext_status_tb;
    import fxs_pkg::*;
    logic clk, srst, ce, soft_reset, status_busy, nv_busy;
    fxs_event_e err_event;
    logic sck, csn, din, qpi_mode, dummy_valid, nv_write_req, cmd_rejected;
    logic [7:0] ext_status;
    logic [3:0] dummy_cycles, drive_eighths;
    logic [2:0] nv_write_data, nv_last, code;
    logic [31:0] seed;
    int num_errors, cmp_count, rej_cnt, nv_cnt;
    // Read table: opcode, command mode, expected dummies (0 = refused)
    logic [15:0] rd_tab [17] = '{16'h0b08, 16'h0d08, 16'h3b08, 16'hbb04, 16'hbd04,
        16'h6b08, 16'heb06, 16'hed06, 16'h4b08, 16'h5a08, 16'h6808, 16'h0b16,
        16'h0d16, 16'heb16, 16'hed16, 16'h4b16, 16'hbd10};
    // Flags expected per event kind: erase, program, protect
    logic [2:0] ev_exp [12] = '{3'h0, 3'h2, 3'h3, 3'h2, 3'h3, 3'h4, 3'h2, 3'h5,
        3'h2, 3'h4, 3'h5, 3'h0};
    fxs_ext_status DUT (.clk(clk), .srst(srst), .ce(ce), .sck(sck), .csn(csn),
        .din(din), .qpi_mode(qpi_mode), .soft_reset(soft_reset),
        .status_busy(status_busy), .nv_busy(nv_busy), .err_event(err_event),
        .ext_status(ext_status), .dummy_cycles(dummy_cycles),
        .dummy_valid(dummy_valid), .drive_eighths(drive_eighths),
        .nv_write_req(nv_write_req), .nv_write_data(nv_write_data),
        .cmd_rejected(cmd_rejected));
    fxs_host_model host (.clk(clk), .sck(sck), .csn(csn), .din(din),
        .qpi_mode(qpi_mode));
    // ============================================================
    // Clock and pulse monitors
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        if (cmd_rejected === 1'b1) rej_cnt++;
        if (nv_write_req === 1'b1) begin
            nv_cnt++;
            nv_last = nv_write_data;
        end
    end
    // ============================================================
    // Helpers
    task automatic rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
    endtask
    function automatic logic [7:0] drv_exp(input logic [2:0] c);
        logic [31:0] lut;
        lut = 32'h4860_3210;
        return {4'h0, lut[c * 4 +: 4]};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic pulse_soft();
        soft_reset <= 1'b1;
        @(posedge clk);
        soft_reset <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic stop_test();
        $display("errors %0d comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ============================================================
    // Watchdog
    initial begin
        #3000000;
        num_errors++;
        $display("wrong value at %0t: watchdog expired", $time);
        stop_test();
    end
    // ============================================================
    // Main sequence
    initial begin
        seed = 32'hd569;
        srst = 1'b1;
        ce = 1'b1;
        soft_reset = 1'b0;
        status_busy = 1'b0;
        nv_busy = 1'b0;
        err_event = FXS_EV_NONE;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        repeat (6) @(posedge clk);
        chk(ext_status, 8'hf0, "reset image");
        chk({4'h0, drive_eighths}, 8'h04, "reset drive");
        // Default dummy counts per read opcode and mode
        foreach (rd_tab[i]) begin
            host.send(1, {rd_tab[i][15:8], 8'h00}, rd_tab[i][4]);
            chk({7'h0, dummy_valid}, {7'h0, rd_tab[i][3:0] != 4'h0}, "read taken");
            if (rd_tab[i][3:0] != 4'h0)
                chk({4'h0, dummy_cycles}, {4'h0, rd_tab[i][3:0]}, "dummies");
            host.finish_frame();
        end
        chk(8'(rej_cnt), 8'h01, "refusals");
        // Every strength code through the volatile set, random low bits ignored
        for (int c = 0; c < 8; c++) begin
            rnd();
            host.send(2, {8'h83, 3'(c), seed[4:0]}, 1'b0);
            host.finish_frame();
            chk(ext_status, {3'(c), 5'h10}, "volatile set");
            chk({4'h0, drive_eighths}, drv_exp(3'(c)), "drive");
        end
        // Non-volatile set, then reload by soft reset, then power-up reset
        rnd();
        code = {seed[7:6], 1'b0};
        host.send(2, {8'h85, code, seed[4:0]}, 1'b0);
        host.finish_frame();
        chk(ext_status, 8'hf0, "volatile kept");
        chk({nv_last, 5'(nv_cnt)}, {code, 5'h01}, "nv request");
        pulse_soft();
        chk(ext_status, {code, 5'h10}, "strength reload");
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        repeat (6) @(posedge clk);
        chk(ext_status, 8'hf0, "second reset");
        // Clock enable low: an event in a frozen cycle leaves no trace
        ce <= 1'b0;
        err_event <= FXS_EV_ERASE_PROT;
        @(posedge clk);
        ce <= 1'b1;
        err_event <= FXS_EV_NONE;
        repeat (3) @(posedge clk);
        chk(ext_status, 8'hf0, "frozen by enable");
        // Every error event, a read while flagged, then a clear
        for (int e = 1; e < 12; e++) begin
            rnd();
            err_event <= fxs_event_e'(e);
            status_busy <= seed[0];
            nv_busy <= seed[1];
            @(posedge clk);
            err_event <= FXS_EV_NONE;
            repeat (3) @(posedge clk);
            chk(ext_status, {4'hf, ev_exp[e], seed[0] | seed[1]}, "flags");
            host.send(1, 16'h0b00, 1'b0);
            chk({4'h0, dummy_cycles}, 8'h08, "read while flagged");
            host.finish_frame();
            chk(ext_status, {4'hf, ev_exp[e], seed[0] | seed[1]}, "sticky");
            if (e % 2 == 1) begin
                host.send(1, 16'h8200, 1'b0);
                host.finish_frame();
            end else begin
                pulse_soft();
            end
            chk(ext_status, {7'h78, seed[0] | seed[1]}, "cleared");
        end
        stop_test();
    end
endmodule // fxs_ext_status_tb
bind fxs_ext_status fxs_ext_status_checker u_chk (.clk(clk), .srst(srst), .ce(ce),
    .csn(csn), .soft_reset(soft_reset), .status_busy(status_busy), .nv_busy(nv_busy),
    .err_event(err_event), .ext_status(ext_status), .dummy_cycles(dummy_cycles),
    .dummy_valid(dummy_valid), .drive_eighths(drive_eighths),
    .nv_write_req(nv_write_req), .cmd_rejected(cmd_rejected));
